// ### logic/gp_timer.sv
// 16-bit general-purpose timer/counter with gated accumulation and RTC source.
// Assumes one 100 MHz clock that is also the instruction-cycle clock, pins
// synchronous to it, and a classic Wishbone master on the register side.
//
// Function
// - Internal mode counts each instruction cycle to period, then wraps to zero.
// - Idle stops counting when idle stop select is one; resumes after Idle.
// - Synchronous counter counts synchronised rising edges of external clock pin.
// - Asynchronous counter counts every external rising edge, unsynchronised, wraps at period.
// - Asynchronous counter also stops in Idle when idle stop select is one.
// - Gated mode counts instruction cycles only while gate pin is high.
// - Prescaler divides input by 1, 8, 64 or 256 per prescale select.
// - Count write, control write or reset clears the prescaler.
// - With the timer off, writes cannot clear the prescaler.
// - Control writes keep the count; only count writes change it.
// - In Sleep only the on, external, asynchronous configuration and the RTC keep counting.
// - Period match sets the timer flag; interrupt if enabled; software clears.
// - Gated mode also flags on falling edge of the gate input.
// - RTC counts rising edges of the low-power oscillator, wrapping at period.
// - Low-power oscillator enable replaces normal modes, enables carry-out wake event.
// - RTC runs in Sleep; in Idle unless idle stop select is set.
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_defs.svh"

module gp_timer #(
    parameter int COUNT_WIDTH = 16,
    parameter int PS_WIDTH = 8
) (
    input wire logic clk_i, // system and instruction-cycle clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic ext_clock_gate_pin_i, // external clock or gate pin
    input wire logic lp_osc_i, // 32 kHz low-power oscillator output
    input wire logic cpu_idle_i, // CPU is in Idle
    input wire logic cpu_sleep_i, // CPU is in Sleep
    output logic irq_o, // level interrupt
    output logic wake_o // carry-out wake event pulse
);
    import gp_timer_pkg::*;

    // Elaboration check: a count wider than the two low byte lanes
    // could not be written in one transfer
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 16) begin : g_bad_count_width
        $error("gp_timer: COUNT_WIDTH must be 2 to 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [COUNT_WIDTH-1:0] count_value;
    logic [COUNT_WIDTH-1:0] period_value;
    logic [15:0] timer_control;
    logic low_power_osc_enable;
    logic [`IRQ_BITS-1:0] irq_status;
    logic [`IRQ_BITS-1:0] irq_mask;

    logic timer_on;
    logic idle_stop_select;
    logic gate_accumulate_enable;
    ps_sel_type prescale_select;
    logic external_sync_select;
    logic clock_source_select;

    assign timer_on = timer_control[`CTL_TIMER_ON];
    assign idle_stop_select = timer_control[`CTL_IDLE_STOP];
    assign gate_accumulate_enable = timer_control[`CTL_GATE_ACC];
    assign prescale_select = timer_control[`CTL_PS_HI:`CTL_PS_LO];
    assign external_sync_select = timer_control[`CTL_EXT_SYNC];
    assign clock_source_select = timer_control[`CTL_CLK_SRC];

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    logic bus_req;
    logic bus_wr;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_osc;
    logic wr_status;
    logic wr_mask;
    logic [31:0] next_rdata;

    // One wait state: ack follows the strobe by one edge, then drops
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i;
    assign wr_count = bus_wr && (wb_adr_i == `OFS_COUNT_VALUE);
    assign wr_period = bus_wr && (wb_adr_i == `OFS_PERIOD_VALUE);
    assign wr_control = bus_wr && (wb_adr_i == `OFS_TIMER_CONTROL);
    assign wr_osc = bus_wr && (wb_adr_i == `OFS_OSC_CONTROL);
    assign wr_status = bus_wr && (wb_adr_i == `OFS_IRQ_STATUS);
    assign wr_mask = bus_wr && (wb_adr_i == `OFS_IRQ_MASK);

    // Merge the two low byte lanes into a 16-bit register value
    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [31:0] data,
                                            input logic [3:0] sel);
        logic [15:0] result;
        result = old_val;
        if (sel[0]) begin
            result[7:0] = data[7:0];
        end
        if (sel[1]) begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            `OFS_COUNT_VALUE: next_rdata[COUNT_WIDTH-1:0] = count_value;
            `OFS_PERIOD_VALUE: next_rdata[COUNT_WIDTH-1:0] = period_value;
            `OFS_TIMER_CONTROL: next_rdata[15:0] = timer_control;
            `OFS_OSC_CONTROL: next_rdata[`OSC_LP_ENABLE] = low_power_osc_enable;
            `OFS_IRQ_STATUS: next_rdata[`IRQ_BITS-1:0] = irq_status;
            `OFS_IRQ_MASK: next_rdata[`IRQ_BITS-1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_control <= `RST_CONTROL;
        end else if (wr_control) begin
            timer_control <= merge16(timer_control, wb_dat_i, wb_sel_i) & `CTL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_value <= COUNT_WIDTH'(`RST_PERIOD);
        end else if (wr_period) begin
            period_value <= COUNT_WIDTH'(merge16(16'(period_value), wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_power_osc_enable <= 1'b0;
            irq_mask <= '0;
        end else begin
            if (wr_osc && wb_sel_i[0]) begin
                low_power_osc_enable <= wb_dat_i[`OSC_LP_ENABLE];
            end
            if (wr_mask && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[`IRQ_BITS-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and edges

    logic ext_sync1;
    logic ext_sync2;
    logic ext_sync3;
    logic ext_prev;
    logic lp_prev;
    logic sync_rise;
    logic async_rise;
    logic lp_rise;
    logic gate_fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_sync3 <= 1'b0;
            ext_prev <= 1'b0;
            lp_prev <= 1'b0;
        end else begin
            ext_sync1 <= ext_clock_gate_pin_i;
            ext_sync2 <= ext_sync1;
            ext_sync3 <= ext_sync2;
            ext_prev <= ext_clock_gate_pin_i;
            lp_prev <= lp_osc_i;
        end
    end

    assign sync_rise = ext_sync2 && !ext_sync3;
    assign async_rise = ext_clock_gate_pin_i && !ext_prev;
    assign lp_rise = lp_osc_i && !lp_prev;
    assign gate_fall = !ext_sync2 && ext_sync3;

    ////////////////////////////////////////////////////////////////////////////
    // Mode and input tick

    mode_type mode;
    logic idle_hold;
    logic raw_tick;
    logic ps_tick;
    logic ps_clear;

    always_comb begin
        if (!timer_on) begin
            mode = MODE_OFF;
        end else if (low_power_osc_enable) begin
            mode = (clock_source_select && !gate_accumulate_enable) ? MODE_RTC : MODE_OFF;
        end else if (!clock_source_select) begin
            mode = gate_accumulate_enable ? MODE_GATED : MODE_TIMER;
        end else begin
            mode = external_sync_select ? MODE_SYNC : MODE_ASYNC;
        end
    end

    assign idle_hold = cpu_idle_i && idle_stop_select;

    always_comb begin
        raw_tick = 1'b0;
        unique case (mode)
            MODE_OFF: raw_tick = 1'b0;
            MODE_TIMER: raw_tick = !cpu_sleep_i;
            MODE_GATED: raw_tick = !cpu_sleep_i && ext_sync2;
            MODE_SYNC: raw_tick = !cpu_sleep_i && sync_rise;
            MODE_ASYNC: raw_tick = async_rise;
            MODE_RTC: raw_tick = lp_rise;
        endcase
        if (idle_hold) begin
            raw_tick = 1'b0;
        end
    end

    assign ps_clear = timer_on && (wr_count || wr_control);

    timer_prescaler #(
        .PS_WIDTH(PS_WIDTH)
    ) u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(ps_clear),
        .tick_i(raw_tick),
        .ratio_i(prescale_select),
        .tick_o(ps_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    logic at_period;
    logic at_period_q;
    logic carry_out;

    assign at_period = (count_value == period_value);
    // wrap on the next prescaled tick after the match
    assign carry_out = ps_tick && at_period && !wr_count;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_value <= COUNT_WIDTH'(`RST_COUNT);
        end else if (wr_count) begin
            count_value <= COUNT_WIDTH'(merge16(16'(count_value), wb_dat_i, wb_sel_i));
        end else if (ps_tick) begin
            count_value <= at_period ? '0 : count_value + COUNT_WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            at_period_q <= 1'b0;
        end else begin
            at_period_q <= at_period;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events and interrupt

    logic match_event;
    logic gate_event;
    logic wake_event;
    logic [`IRQ_BITS-1:0] set_bits;
    logic [`IRQ_BITS-1:0] clr_bits;

    // flag on entering a match while running
    assign match_event = timer_on && at_period && !at_period_q;
    assign gate_event = (mode == MODE_GATED) && gate_fall;
    assign wake_event = (mode == MODE_RTC) && carry_out;

    always_comb begin
        set_bits = '0;
        set_bits[`IRQ_TIMER] = match_event || gate_event;
        set_bits[`IRQ_WAKE] = wake_event;
        clr_bits = (wr_status && wb_sel_i[0]) ? wb_dat_i[`IRQ_BITS-1:0] : '0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~clr_bits) | set_bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= wake_event;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

endmodule // gp_timer

`default_nettype wire

// ### logic/gp_timer_defs.svh
// Constants of the 16-bit timer: register map, field positions, reset values.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef GP_TIMER_DEFS_SVH
`define GP_TIMER_DEFS_SVH

// Register byte offsets
`define OFS_COUNT_VALUE 8'h00
`define OFS_PERIOD_VALUE 8'h04
`define OFS_TIMER_CONTROL 8'h08
`define OFS_OSC_CONTROL 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// timer_control fields
`define CTL_TIMER_ON 15
`define CTL_IDLE_STOP 13
`define CTL_GATE_ACC 6
`define CTL_PS_HI 5
`define CTL_PS_LO 4
`define CTL_EXT_SYNC 2
`define CTL_CLK_SRC 1
`define CTL_WRITE_MASK 16'hA076

// oscillator_control fields
`define OSC_LP_ENABLE 1

// Status and mask bits
`define IRQ_TIMER 0
`define IRQ_WAKE 1
`define IRQ_BITS 2

// Reset values
`define RST_COUNT 16'h0000
`define RST_PERIOD 16'hFFFF
`define RST_CONTROL 16'h0000

// Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
`define PS_LAST_1 8'h00
`define PS_LAST_8 8'h07
`define PS_LAST_64 8'h3F
`define PS_LAST_256 8'hFF

`endif

// ### logic/gp_timer_pkg.sv
// Types shared by the timer files.
// Assumes the constants header is included by the files that need numbers.
`default_nettype none
package gp_timer_pkg;

    // Active counting source, one-hot
    typedef enum logic [5:0] {
        MODE_OFF = 6'b00_0001,
        MODE_TIMER = 6'b00_0010,
        MODE_GATED = 6'b00_0100,
        MODE_SYNC = 6'b00_1000,
        MODE_ASYNC = 6'b01_0000,
        MODE_RTC = 6'b10_0000
    } mode_type;

    typedef logic [1:0] ps_sel_type;

endpackage

`default_nettype wire

// ### logic/timer_prescaler.sv
// Prescaler of the timer input clock: passes one of every 1, 8, 64 or 256 ticks.
// Assumes tick_i is a one-cycle pulse; clear_i has priority over counting.
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_defs.svh"

module timer_prescaler #(
    parameter int PS_WIDTH = 8
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic clear_i, // clear the prescale counter
    input wire logic tick_i, // input clock event
    input wire gp_timer_pkg::ps_sel_type ratio_i, // prescale select
    output logic tick_o // prescaled event, combinational
);
    import gp_timer_pkg::*;

    logic [PS_WIDTH-1:0] count;
    logic [PS_WIDTH-1:0] last;

    // Elaboration check: the widest ratio needs eight counter bits
    if (PS_WIDTH < 8) begin : g_bad_ps_width
        $error("timer_prescaler: PS_WIDTH must be at least 8");
    end

    always_comb begin
        unique case (ratio_i)
            2'd0: last = PS_WIDTH'(`PS_LAST_1);
            2'd1: last = PS_WIDTH'(`PS_LAST_8);
            2'd2: last = PS_WIDTH'(`PS_LAST_64);
            2'd3: last = PS_WIDTH'(`PS_LAST_256);
        endcase
    end

    assign tick_o = tick_i && !clear_i && (count >= last);

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count <= '0;
        end else if (tick_i) begin
            count <= (count >= last) ? '0 : count + PS_WIDTH'(1);
        end
    end

endmodule // timer_prescaler

`default_nettype wire

// ### testbench/gp_timer_asserts.sv
// Checker of the timer's bus and event ports.
// Assumes it is bound into gp_timer; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module gp_timer_asserts (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset, high
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic lp_osc_i, // oscillator
    input wire logic irq_o, // interrupt
    input wire logic wake_o // wake pulse
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic osc_q;
    logic [2:0] since_rise;
    // Saturates so a wake long after any oscillator edge is caught
    always_ff @(posedge clk_i) begin
        osc_q <= lp_osc_i;
        if (lp_osc_i && !osc_q) since_rise <= 3'h0;
        else if (since_rise != 3'h7) since_rise <= since_rise + 3'h1;
    end
    AST_ACK_AFTER_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_NEEDS_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !irq_o && !wake_o && !wb_ack_o)
        else $error("outputs active after reset");
    AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    AST_WAKE_FROM_OSC: assert property (wake_o |-> since_rise <= 3'h5)
        else $error("wake without oscillator edge");
    AST_IRQ_FALLS_ON_WRITE: assert property ($fell(irq_o) |-> wb_ack_o && $past(wb_we_i))
        else $error("interrupt dropped without a write");
endmodule // gp_timer_asserts
bind gp_timer gp_timer_asserts gp_timer_asserts_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_dat_o, .wb_ack_o, .lp_osc_i, .irq_o, .wake_o);
`default_nettype wire

// ### testbench/ext_source.sv
// Far side: external clock or gate pin and the 32 kHz oscillator.
// Assumes a 100 MHz clk_i; everything changes just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ext_source #(
    parameter int OSC_HALF = 1526 // Cycles per oscillator half period
) (
    input wire logic clk_i, // system clock
    input wire logic osc_run_i, // oscillator powered
    output logic pin_o, // pin level
    output logic osc_o // oscillator output
);
    logic [11:0] osc_cnt;
    initial pin_o = 1'b0;
    initial osc_o = 1'b0;
    always @(posedge clk_i) begin
        if (!osc_run_i) begin
            osc_cnt <= 12'h000;
            osc_o <= 1'b0;
        end else if (osc_cnt == 12'(OSC_HALF - 1)) begin
            osc_cnt <= 12'h000;
            osc_o <= ~osc_o;
        end else begin
            osc_cnt <= osc_cnt + 12'h001;
        end
    end
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task automatic level(input logic v);
        @(posedge clk_i);
        pin_o <= v;
    endtask
endmodule // ext_source
`default_nettype wire

// ### testbench/gp_timer_16bit_with_rtc_bench.sv
// Self-checking bench of the timer over its Wishbone port.
// Assumes the checker is bound in and ext_source drives the pins.
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_defs.svh"
module gp_timer_16bit_with_rtc_bench;
    localparam logic [7:0] CNT = `OFS_COUNT_VALUE;
    localparam logic [7:0] CTL = `OFS_TIMER_CONTROL;
    localparam logic [7:0] STA = `OFS_IRQ_STATUS;
    localparam logic [7:0] MSK = `OFS_IRQ_MASK;
    logic clk, ack, irq, wake, pin, osc;
    logic rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, sleep = 1'b0;
    logic osc_run = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [15:0] q;
    int errors = 0, tests_run = 0, wakes = 0;
    typedef struct { logic [15:0] ctl; int np; int nw; logic [15:0] cnt; } row_type;
    row_type rows [8] = '{
        '{16'h8010, 0, 41, 16'h0005},
        '{16'h8020, 0, 221, 16'h0003},
        '{16'h8030, 0, 637, 16'h0002},
        '{16'h8002, 7, 4, 16'h0007},
        '{16'h8006, 6, 6, 16'h0006},
        '{16'h8016, 17, 6, 16'h0002},
        '{16'h8040, 0, 30, 16'h0000},
        '{16'h0002, 5, 4, 16'h0000}};
    gp_timer gp_timer_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_clock_gate_pin_i(pin), .lp_osc_i(osc), .cpu_idle_i(idle),
        .cpu_sleep_i(sleep), .irq_o(irq), .wake_o(wake));
    ext_source ext_source_inst (.clk_i(clk), .osc_run_i(osc_run), .pin_o(pin), .osc_o(osc));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    // Request held until ack is sampled high; data taken at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        // A slave that never answers ends the run here
        if (ack !== 1'b1) begin
            chk("ack", 16'h0001, 16'h0000);
            give_verdict();
        end
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000);
        chk(nm, e, q);
    endtask
    task automatic run(input logic [15:0] c, input int np, input int nw);
        wr(CNT, 16'h0000);
        wr(CTL, c);
        ext_source_inst.pulses(np);
        repeat (nw) @(posedge clk);
        wr(CTL, 16'h0000);
        xfer(1'b0, CNT, 16'h0000);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        give_verdict();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            run(rows[i].ctl, rows[i].np, rows[i].nw);
            chk("row count", rows[i].cnt, q);
        end
        do_reset();
        rdchk("period", `OFS_PERIOD_VALUE, 16'hFFFF);
        rdchk("control", CTL, 16'h0000);
        wr(8'h18, 16'h5555);
        rdchk("unmapped", 8'h18, 16'h0000);
        wr(CNT, 16'h1234);
        wr(CTL, 16'h2076);
        rdchk("count kept", CNT, 16'h1234);
        rdchk("control rb", CTL, 16'h2076);
        wr(MSK, 16'h0001);
        wr(`OFS_PERIOD_VALUE, 16'h0004);
        // 22 counted cycles through a period of five values leave two
        run(16'h8000, 0, 20);
        chk("wrap range", 16'h0002, q);
        chk("irq set", 16'h0001, {15'h0000, irq});
        wr(STA, 16'h0001);
        chk("irq clear", 16'h0000, {15'h0000, irq});
        wr(MSK, 16'h0000);
        run(16'h8000, 0, 10);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        rdchk("status", STA, 16'h0001);
        wr(MSK, 16'h0001);
        chk("irq unmask", 16'h0001, {15'h0000, irq});
        wr(STA, 16'h0001);
        wr(`OFS_PERIOD_VALUE, 16'hFFFF);
        idle <= 1'b1;
        run(16'hA000, 0, 30);
        chk("idle stop", 16'h0000, q);
        run(16'hA002, 3, 4);
        chk("idle async", 16'h0000, q);
        run(16'h8000, 0, 30);
        chk("idle run", 16'h0020, q);
        idle <= 1'b0;
        run(16'hA000, 0, 30);
        chk("idle over", 16'h0020, q);
        sleep <= 1'b1;
        run(16'h8000, 0, 30);
        chk("sleep timer", 16'h0000, q);
        run(16'h8006, 3, 6);
        chk("sleep sync", 16'h0000, q);
        run(16'h8002, 3, 4);
        chk("sleep async", 16'h0003, q);
        sleep <= 1'b0;
        wr(CNT, 16'h0000);
        wr(CTL, 16'h8040);
        ext_source_inst.level(1'b1);
        repeat (10) @(posedge clk);
        ext_source_inst.level(1'b0);
        repeat (6) @(posedge clk);
        wr(CTL, 16'h0000);
        rdchk("gate flag", STA, 16'h0001);
        xfer(1'b0, CNT, 16'h0000);
        // Pin stood high for eleven cycles, so eleven are accumulated
        chk("gate count", 16'h000B, q);
        wr(STA, 16'h0001);
        wr(`OFS_PERIOD_VALUE, 16'h0001);
        wr(CNT, 16'h0000);
        wr(`OFS_OSC_CONTROL, 16'h0002);
        // Sync select kept zero while the oscillator drives the count
        wr(CTL, 16'h8002);
        // Sleep held through the run: the clock must not notice it
        sleep <= 1'b1;
        osc_run <= 1'b1;
        ext_source_inst.pulses(5);
        repeat (11500) @(posedge clk);
        osc_run <= 1'b0;
        sleep <= 1'b0;
        wr(CTL, 16'h0000);
        chk("wake pulses", 16'h0002, wakes[15:0]);
        rdchk("rtc count", CNT, 16'h0000);
        rdchk("rtc flags", STA, 16'h0003);
        give_verdict();
    end
endmodule // gp_timer_16bit_with_rtc_bench
`default_nettype wire
